// ---- rtl/mlsi_pkg.sv ----
// Purpose: constants for the local start and interlock block
// Assumes: 100 MHz scan clock, AHB-Lite register access
// Notes: counts in cycles are derived from times in milliseconds
//
// Summary of operation
// - local start buttons start the device only while local mode is selected.
// - in local mode a rising press of either button pulses an alarm acknowledge for all.
// - with lamp check allowed, a press while running tests the lamps instead of starting.
// - in local mode a held button with bypass not inhibited bridges machine protection.
// - with horn configured, press one sounds the horn and press two after it starts.
// - without a second press inside the window after the horn, the sequence is abandoned.
// - with single press selected, one press is enough to start.
// - two directional buttons exist, open and close, each acting as the local start.
// - a start needs the isolator input high.
// - isolator low while running latches a failure cleared only by parent restart or reset.
// - a start needs the breaker high; its loss while running latches the failure.
// - a start needs overload healthy high; its loss while running latches the failure.
// - machine protection must be high to run unless bridged by a held local start.
package mlsi_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_HORN = 8'h04;
   localparam logic [7:0] ADDR_WIN = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   // control field positions
   localparam int CTRL_LOCAL = 0;
   localparam int CTRL_LAMP = 1;
   localparam int CTRL_INHIBIT = 2;
   localparam int CTRL_HORN = 3;
   localparam int CTRL_SINGLE = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // status field positions
   localparam int ST_PERMIT = 0;
   localparam int ST_FAIL = 1;
   localparam int ST_HORN = 2;
   localparam int ST_WAIT = 3;
   localparam int ST_BYPASS = 4;
   localparam int ST_LAMP = 5;
   localparam int ST_RUN = 6;
   // timing
   localparam int unsigned CLK_KHZ = 32'd100_000;
   localparam int unsigned HORN_MS = 32'd5000;
   localparam int unsigned WIN_MS = 32'd10000;
   localparam logic [31:0] HORN_CYCLES = 32'(HORN_MS * CLK_KHZ);
   localparam logic [31:0] WIN_CYCLES = 32'(WIN_MS * CLK_KHZ);
   // local start sequence
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_HORN = 2'b01,
      SEQ_WAIT = 2'b10
   } mlsi_seq_t;
endpackage

// ---- rtl/mlsi_sync.sv ----
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to clock
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps
module mlsi_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;
   logic [W-1:0] agree;

   // bits whose later stages match
   assign agree = ~(s2_q ^ s3_q);
   assign dout = out_q;

   // stage chain and filtered output
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         out_q <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= (agree & s3_q) | (~agree & out_q);
      end
   end
endmodule

// ---- rtl/mlsi_timer.sv ----
// Purpose: loadable down counter for horn and press window
// Assumes: load is a single-cycle strobe; abort may be a held level
// Notes: done pulses one cycle when a loaded count expires
`timescale 1ns/1ps
module mlsi_timer (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // control
   input wire logic load,
   input wire logic abort,
   input wire logic [31:0] load_val,
   // status
   output logic busy,
   output logic done
);
   logic [31:0] cnt_q;
   logic busy_q;
   logic done_q;
   logic last;

   assign last = busy_q && (cnt_q <= 32'h0000_0001);
   assign busy = busy_q;
   assign done = done_q;

   // load wins over abort, count down to expiry
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 32'h0000_0000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else if (load) begin
         cnt_q <= load_val;
         busy_q <= 1'b1;
         done_q <= 1'b0;
      end else begin
         cnt_q <= busy_q ? cnt_q - 32'h0000_0001 : cnt_q;
         busy_q <= busy_q && !last && !abort;
         done_q <= last && !abort;
      end
   end
endmodule

// ---- rtl/mlsi_top.sv ----
// Purpose: local start permission, interlock bridging and trip latch
// Assumes: field pins asynchronous; parent restart on the scan clock
// Notes: registers reached over AHB-Lite, zero wait states
// Notes: a pin change is seen inside four clocks after it settles
`timescale 1ns/1ps
module mlsi_top #(
   parameter logic [31:0] HORN_DEFAULT = mlsi_pkg::HORN_CYCLES,
   parameter logic [31:0] WIN_DEFAULT = mlsi_pkg::WIN_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // field inputs
   input wire logic local_start_open_dir,
   input wire logic local_start_close_dir,
   input wire logic isolator_closed,
   input wire logic breaker_closed,
   input wire logic overload_ok,
   input wire logic machine_protection_ok,
   input wire logic running_fb,
   // parent group
   input wire logic parent_group_restart,
   // outputs
   output logic start_open,
   output logic start_close,
   output logic alarm_ack,
   output logic lamp_test,
   output logic horn_on,
   output logic start_permit,
   output logic failed,
   output logic mp_bridged
);
   // field levels before and after the synchroniser
   logic [6:0] pins;
   logic [6:0] pins_s;
   logic gx;
   logic gy;
   logic iso;
   logic brk;
   logic ovl;
   logic mpi;
   logic run;

   // button history and decode
   logic gx_prev_q;
   logic gy_prev_q;
   logic press;
   logic press_close;
   logic dir_close;
   logic held;

   // register file and bus side
   logic [4:0] ctrl_q;
   logic [31:0] horn_q;
   logic [31:0] win_q;
   logic [31:0] rdata_q;
   logic [7:0] waddr_q;
   logic wr_q;
   logic addr_ok;
   logic [31:0] rd_mux;
   logic [31:0] status;

   // permission, trip and start sequence
   logic local_mode;
   logic bypass;
   logic mp_eff;
   logic supply_ok;
   logic permit;
   logic trip;
   logic fail_q;
   logic start_req;
   logic go_now;
   logic direct;
   logic tmr_load;
   logic [31:0] tmr_val;
   logic tmr_done;
   logic seq_abort;
   logic close_q;

   // registered outputs and sequence state
   logic start_open_q;
   logic start_close_q;
   logic ack_q;
   logic lamp_q;
   logic horn_q2;
   logic permit_q;
   logic bridged_q;
   mlsi_pkg::mlsi_seq_t seq_q;
   mlsi_pkg::mlsi_seq_t seq_d;

   // field pin synchronisers
   assign pins = {running_fb, machine_protection_ok, overload_ok, breaker_closed,
                  isolator_closed, local_start_close_dir, local_start_open_dir};
   mlsi_sync #(.W(7)) u_sync (
      .clock(clock),
      .rstn(rstn),
      .din(pins),
      .dout(pins_s)
   );
   assign gx = pins_s[0];
   assign gy = pins_s[1];
   assign iso = pins_s[2];
   assign brk = pins_s[3];
   assign ovl = pins_s[4];
   assign mpi = pins_s[5];
   assign run = pins_s[6];

   // previous samples of the buttons
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gx_prev_q <= 1'b0;
         gy_prev_q <= 1'b0;
      end else begin
         gx_prev_q <= gx;
         gy_prev_q <= gy;
      end
   end

   // rising edge of a synchronised button against its last sample
   function automatic logic rise(input logic now, input logic last);
      return now && !last;
   endfunction

   // button decode; open and close act alike
   assign press = rise(gx, gx_prev_q) || rise(gy, gy_prev_q);
   assign press_close = rise(gy, gy_prev_q);
   // direction of this press, or of the last one while the sequence runs
   assign dir_close = press ? press_close : close_q;
   assign held = gx || gy;
   assign local_mode = ctrl_q[mlsi_pkg::CTRL_LOCAL];

   // interlock bridging and start permission
   assign bypass = local_mode && held && !ctrl_q[mlsi_pkg::CTRL_INHIBIT];
   assign mp_eff = mpi || bypass;
   assign supply_ok = iso && brk && ovl;
   assign permit = supply_ok && mp_eff && !fail_q;
   assign trip = run && !supply_ok;

   // failure latch; a trip in the restart cycle keeps it set
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fail_q <= 1'b0;
      end else begin
         fail_q <= trip || (fail_q && !parent_group_restart);
      end
   end

   // press qualifies as a start only in local mode while stopped
   assign start_req = local_mode && press && !run && permit;
   assign direct = !ctrl_q[mlsi_pkg::CTRL_HORN] || ctrl_q[mlsi_pkg::CTRL_SINGLE];
   assign seq_abort = !local_mode || !permit;

   // local start sequence
   always_comb begin
      seq_d = seq_q;
      go_now = 1'b0;
      tmr_load = 1'b0;
      tmr_val = horn_q;
      unique case (seq_q)
         mlsi_pkg::SEQ_IDLE: begin
            if (start_req && !ctrl_q[mlsi_pkg::CTRL_HORN]) begin
               go_now = 1'b1;
            end else if (start_req) begin
               seq_d = mlsi_pkg::SEQ_HORN;
               tmr_load = 1'b1;
            end
         end
         mlsi_pkg::SEQ_HORN: begin
            if (seq_abort) begin
               seq_d = mlsi_pkg::SEQ_IDLE;
            end else if (tmr_done && direct) begin
               seq_d = mlsi_pkg::SEQ_IDLE;
               go_now = 1'b1;
            end else if (tmr_done) begin
               seq_d = mlsi_pkg::SEQ_WAIT;
               tmr_load = 1'b1;
               tmr_val = win_q;
            end
         end
         mlsi_pkg::SEQ_WAIT: begin
            if (seq_abort) begin
               seq_d = mlsi_pkg::SEQ_IDLE;
            end else if (start_req) begin
               seq_d = mlsi_pkg::SEQ_IDLE;
               go_now = 1'b1;
            end else if (tmr_done) begin
               seq_d = mlsi_pkg::SEQ_IDLE;
            end
         end
         default: begin
            seq_d = mlsi_pkg::SEQ_IDLE;
         end
      endcase
   end

   // one timer serves horn and window; a load outranks an abort
   mlsi_timer u_timer (
      .clock(clock),
      .rstn(rstn),
      .load(tmr_load),
      .abort(seq_abort),
      .load_val(tmr_val),
      .busy(),
      .done(tmr_done)
   );

   // sequence state and direction memory
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         seq_q <= mlsi_pkg::SEQ_IDLE;
         close_q <= 1'b0;
      end else begin
         seq_q <= seq_d;
         close_q <= dir_close;
      end
   end

   // registered field-side outputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         start_open_q <= 1'b0;
         start_close_q <= 1'b0;
         ack_q <= 1'b0;
         lamp_q <= 1'b0;
         horn_q2 <= 1'b0;
         permit_q <= 1'b0;
         bridged_q <= 1'b0;
      end else begin
         start_open_q <= go_now && !dir_close;
         start_close_q <= go_now && dir_close;
         ack_q <= local_mode && press;
         lamp_q <= ctrl_q[mlsi_pkg::CTRL_LAMP] && run && held;
         horn_q2 <= (seq_d == mlsi_pkg::SEQ_HORN);
         permit_q <= permit;
         bridged_q <= bypass;
      end
   end

   assign start_open = start_open_q;
   assign start_close = start_close_q;
   assign alarm_ack = ack_q;
   assign lamp_test = lamp_q;
   assign horn_on = horn_q2;
   assign start_permit = permit_q;
   assign failed = fail_q;
   assign mp_bridged = bridged_q;

   // status word, one flag per field position
   always_comb begin
      status = 32'h0000_0000;
      status[mlsi_pkg::ST_PERMIT] = permit_q;
      status[mlsi_pkg::ST_FAIL] = fail_q;
      status[mlsi_pkg::ST_HORN] = horn_q2;
      status[mlsi_pkg::ST_WAIT] = (seq_q == mlsi_pkg::SEQ_WAIT);
      status[mlsi_pkg::ST_BYPASS] = bridged_q;
      status[mlsi_pkg::ST_LAMP] = lamp_q;
      status[mlsi_pkg::ST_RUN] = run;
   end

   // ahb-lite decode
   assign addr_ok = hsel && hready && htrans[1];
   assign rd_mux = (haddr == mlsi_pkg::ADDR_CTRL) ? {27'h000_0000, ctrl_q} :
                   (haddr == mlsi_pkg::ADDR_HORN) ? horn_q :
                   (haddr == mlsi_pkg::ADDR_WIN) ? win_q :
                   (haddr == mlsi_pkg::ADDR_STAT) ? status : 32'h0000_0000;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   // address phase capture and read data
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_q <= 1'b0;
         waddr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_q <= addr_ok && hwrite;
         waddr_q <= haddr;
         rdata_q <= (addr_ok && !hwrite) ? rd_mux : rdata_q;
      end
   end

   // register writes in the data phase
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= mlsi_pkg::CTRL_RESET;
         horn_q <= HORN_DEFAULT;
         win_q <= WIN_DEFAULT;
      end else if (wr_q) begin
         ctrl_q <= (waddr_q == mlsi_pkg::ADDR_CTRL) ? hwdata[4:0] : ctrl_q;
         horn_q <= (waddr_q == mlsi_pkg::ADDR_HORN) ? hwdata : horn_q;
         win_q <= (waddr_q == mlsi_pkg::ADDR_WIN) ? hwdata : win_q;
      end
   end
endmodule

// ---- bench/mlsi_monitor.sv ----
// Purpose: port checker for the local start block
// Assumes: zero wait bus, registered outputs, short field synchroniser
// Notes: bound to the top module from the testbench file
`timescale 1ns/1ps
module mlsi_monitor (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // field contacts and parent
   input wire logic isolator_closed,
   input wire logic breaker_closed,
   input wire logic overload_ok,
   input wire logic parent_group_restart,
   // block outputs
   input wire logic start_open,
   input wire logic start_close,
   input wire logic alarm_ack,
   input wire logic horn_on,
   input wire logic start_permit,
   input wire logic failed
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // a contact gone long enough to pass the synchroniser
   sequence s_contact_lost;
      !(isolator_closed && breaker_closed && overload_ok) [*6];
   endsequence
   // any start pulse
   sequence s_start;
      start_open || start_close;
   endsequence
   a_start_one_dir: assert property (!(start_open && start_close))
      else $error("start pulses on both directions");
   a_start_is_pulse: assert property (s_start |=> !(start_open || start_close))
      else $error("start pulse longer than one cycle");
   a_ack_is_pulse: assert property (alarm_ack |=> !alarm_ack)
      else $error("alarm acknowledge longer than one cycle");
   a_trip_holds: assert property (failed && !parent_group_restart |=> failed)
      else $error("failure cleared without restart");
   a_fail_no_permit: assert property (failed [*2] |-> !start_permit)
      else $error("permit given while failed");
   a_lost_no_permit: assert property (s_contact_lost |-> !start_permit)
      else $error("permit given with a contact open");
   a_start_not_failed: assert property (s_start |-> !failed)
      else $error("start issued while failed");
   a_no_start_horn: assert property (horn_on && $past(horn_on) |-> !start_open && !start_close)
      else $error("start issued during horn");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
endmodule

// ---- bench/mlsi_field.sv ----
// Purpose: field model for buttons and contacts
// Assumes: bench requests button and contact levels
// Notes: never presses both directions at once
`timescale 1ns/1ps
module mlsi_field #(
   parameter bit HAS_ISO = 1'b1
) (
   // requests from the bench
   input wire logic [1:0] btn_req,
   input wire logic [2:0] contact_req,
   // field pins
   output logic local_start_open_dir,
   output logic local_start_close_dir,
   output logic isolator_closed,
   output logic breaker_closed,
   output logic overload_ok
);
   // buttons are exclusive; close wins a double request
   assign local_start_close_dir = btn_req[1];
   assign local_start_open_dir = btn_req[0] && !btn_req[1];
   // a missing isolator reads as closed
   assign isolator_closed = HAS_ISO ? contact_req[0] : 1'b1;
   assign breaker_closed = contact_req[1];
   assign overload_ok = contact_req[2];
endmodule

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for the local start block
// Assumes: horn of 20 and window of 40 cycles
// Notes: buttons and contacts come from the field model; machine protection and run feedback come from the bench
`timescale 1ns/1ps
module testbench;
   localparam logic [31:0] HORN = 32'h0000_0014;
   localparam logic [31:0] WIN = 32'h0000_0028;
   logic clock = 1'b0;
   logic rstn, hsel, hwrite, mp_ok, run_fb, restart;
   logic [1:0] htrans, btn_req;
   logic [2:0] contact_req;
   logic [7:0] haddr, s;
   logic [31:0] hwdata, hrdata, rd;
   logic hready, hresp, so, sc, ack, lamp, horn, permit, failed, bridged, iso, brk, ovl, lso, lsc;
   int fails = 0;
   int n_checks = 0;
   wire logic [7:0] obs = {bridged, failed, permit, horn, lamp, ack, sc, so};
   // clock
   always #5 clock = ~clock;
   mlsi_top #(.HORN_DEFAULT(HORN), .WIN_DEFAULT(WIN)) DUT (.clock(clock), .rstn(rstn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .local_start_open_dir(lso), .local_start_close_dir(lsc), .isolator_closed(iso),
      .breaker_closed(brk), .overload_ok(ovl), .machine_protection_ok(mp_ok),
      .running_fb(run_fb), .parent_group_restart(restart), .start_open(so),
      .start_close(sc), .alarm_ack(ack), .lamp_test(lamp), .horn_on(horn),
      .start_permit(permit), .failed(failed), .mp_bridged(bridged));
   mlsi_field FIELD (.btn_req(btn_req), .contact_req(contact_req),
      .local_start_open_dir(lso), .local_start_close_dir(lsc), .isolator_closed(iso),
      .breaker_closed(brk), .overload_ok(ovl));
   // compare tasks
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_word(what, {31'h0, exp}, {31'h0, got});
   endtask
   // one ahb-lite single transfer
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic ctrl(input logic [31:0] v);
      bus(1'b1, mlsi_pkg::ADDR_CTRL, v);
   endtask
   // press for hold+1 cycles while collecting outputs over n cycles
   task automatic act(input logic [1:0] b, input int hold, input int n);
      s = 8'h00;
      @(posedge clock);
      btn_req <= b;
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         s = s | obs;
         if (i == hold) btn_req <= 2'h0;
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (8000) @(posedge clock);
      fails++;
      wrap_up;
   end
   // tests
   initial begin
      {rstn, hsel, hwrite, run_fb, restart, htrans, btn_req, haddr, hwdata} = '0;
      contact_req = 3'h7;
      mp_ok = 1'b1;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      act(2'h0, 0, 6);
      bus(1'b0, mlsi_pkg::ADDR_CTRL, 32'h0);
      chk_word("ctrl reset", 32'h0000_0000, rd);
      bus(1'b0, mlsi_pkg::ADDR_HORN, 32'h0);
      chk_word("horn reset", HORN, rd);
      bus(1'b0, mlsi_pkg::ADDR_WIN, 32'h0);
      chk_word("window reset", WIN, rd);
      bus(1'b1, mlsi_pkg::ADDR_WIN, 32'h0000_0033);
      bus(1'b0, mlsi_pkg::ADDR_WIN, 32'h0);
      chk_word("window write", 32'h0000_0033, rd);
      bus(1'b1, mlsi_pkg::ADDR_WIN, WIN);
      bus(1'b1, 8'h10, 32'hFFFF_FFFF);
      bus(1'b0, 8'h10, 32'h0);
      chk_word("unmapped", 32'h0000_0000, rd);
      $display("test registers done");
      act(2'h1, 6, 20);
      chk_bit("start outside local", 1'b0, s[0]);
      chk_bit("ack outside local", 1'b0, s[2]);
      ctrl(32'h0000_0001);
      act(2'h1, 6, 20);
      chk_bit("open start", 1'b1, s[0]);
      chk_bit("ack in local", 1'b1, s[2]);
      act(2'h2, 6, 20);
      chk_bit("close start", 1'b1, s[1]);
      chk_bit("no open on close", 1'b0, s[0]);
      $display("test local start done");
      run_fb <= 1'b1;
      ctrl(32'h0000_0003);
      act(2'h1, 6, 20);
      chk_bit("lamp test", 1'b1, s[3]);
      chk_bit("no start running", 1'b0, s[0]);
      $display("test lamp done");
      for (int i = 0; i < 3; i++) begin
         run_fb <= 1'b1;
         contact_req <= 3'h7 ^ (3'h1 << i);
         act(2'h0, 0, 12);
         chk_bit("trip latched", 1'b1, s[6]);
         run_fb <= 1'b0;
         contact_req <= 3'h7;
         act(2'h0, 0, 10);
         chk_bit("trip held", 1'b1, failed);
         restart <= 1'b1;
         act(2'h0, 0, 1);
         restart <= 1'b0;
         act(2'h0, 0, 3);
         chk_bit("trip cleared", 1'b0, failed);
      end
      $display("test trips done");
      // latch a trip, read it back, then clear it by a reset in mid-run
      run_fb <= 1'b1;
      contact_req <= 3'h6;
      act(2'h0, 0, 12);
      bus(1'b0, mlsi_pkg::ADDR_STAT, 32'h0);
      chk_word("status tripped", (32'h0000_0001 << mlsi_pkg::ST_FAIL) |
         (32'h0000_0001 << mlsi_pkg::ST_RUN), rd);
      rstn <= 1'b0;
      act(2'h0, 0, 2);
      chk_bit("fail cleared by reset", 1'b0, failed);
      run_fb <= 1'b0;
      contact_req <= 3'h7;
      rstn <= 1'b1;
      act(2'h0, 0, 6);
      bus(1'b0, mlsi_pkg::ADDR_CTRL, 32'h0);
      chk_word("ctrl after reset", 32'h0000_0000, rd);
      chk_bit("no fail after reset", 1'b0, failed);
      $display("test mid-run reset done");
      mp_ok <= 1'b0;
      ctrl(32'h0000_0001);
      act(2'h1, 10, 14);
      chk_bit("bridged", 1'b1, s[7]);
      chk_bit("bridged start", 1'b1, s[0]);
      ctrl(32'h0000_0005);
      act(2'h1, 10, 14);
      chk_bit("bridge inhibited", 1'b0, s[7]);
      chk_bit("no start unprotected", 1'b0, s[0]);
      act(2'h0, 0, 6);
      chk_bit("no permit unprotected", 1'b0, permit);
      mp_ok <= 1'b1;
      $display("test bridge done");
      ctrl(32'h0000_0009);
      act(2'h1, 3, 12);
      chk_bit("horn sounds", 1'b1, s[4]);
      chk_bit("no start first press", 1'b0, s[0]);
      act(2'h0, 0, 30);
      act(2'h1, 3, 12);
      chk_bit("second press start", 1'b1, s[0]);
      act(2'h1, 3, 12);
      act(2'h0, 0, 80);
      act(2'h1, 3, 12);
      chk_bit("late press no start", 1'b0, s[0]);
      chk_bit("late press new horn", 1'b1, s[4]);
      act(2'h0, 0, 90);
      $display("test horn done");
      ctrl(32'h0000_0019);
      act(2'h1, 3, 40);
      chk_bit("single press horn", 1'b1, s[4]);
      chk_bit("single press start", 1'b1, s[0]);
      $display("test single press done");
      wrap_up;
   end
endmodule
bind mlsi_top mlsi_monitor u_mon (.clock(clock), .rstn(rstn), .hreadyout(hreadyout),
   .hresp(hresp), .isolator_closed(isolator_closed), .breaker_closed(breaker_closed),
   .overload_ok(overload_ok), .parent_group_restart(parent_group_restart),
   .start_open(start_open), .start_close(start_close), .alarm_ack(alarm_ack),
   .horn_on(horn_on), .start_permit(start_permit), .failed(failed));
